// ### rtl/rct_defs.vh
/*
 Constants of the reset cause tracking block: register offsets, bit positions,
 reset values and filter counts. Definitions only.
*/
`ifndef RCT_DEFS_VH
`define RCT_DEFS_VH

// Byte offsets of the Wishbone registers
`define RCT_ADDR_CAUSE      4'h0
`define RCT_ADDR_IRQ_STAT   4'h4
`define RCT_ADDR_IRQ_MASK   4'h8
`define RCT_ADDR_PIN        4'hc

// Reset cause register layout
`define RCT_BIT_BOR         0
`define RCT_BIT_POR         1
`define RCT_BIT_PD          2
`define RCT_BIT_TO          3
`define RCT_BIT_RI          4
`define RCT_BIT_SOFT_BROWNOUT_ENABLE      6
`define RCT_BIT_PRIORITY_LEVELS_ENABLE        7

// Status/mask layout of event bits
`define RCT_EV_POR          0
`define RCT_EV_BOR          1
`define RCT_EV_PIN_RUN      2
`define RCT_EV_PIN_PM       3
`define RCT_EV_WDT          4
`define RCT_EV_RI           5
`define RCT_EV_STKFUL       6
`define RCT_EV_STKUNF       7
`define RCT_EV_W            8

// Reset values
`define RCT_CAUSE_RESET     8'h1f
`define RCT_STKFLAG_RESET   2'h0
`define RCT_MASK_RESET      8'h00

// Reset pin filter: least low time in ns and derived cycle count
`define RCT_CLK_PERIOD_NS   10
`define RCT_FILT_NS         200
`define RCT_FILT_CYC        8'h14
`define RCT_FILT_W          8
`define RCT_PULSE_CYC       3'h4

`endif

// ### rtl/rct_pin_filter.v
/*
 Reset pin filter: two-flop synchroniser then a low-time counter.
 Assumes the pin is sampled in the clk_i domain.
*/
`timescale 1ns/1ps
`include "rct_defs.vh"
module rct_pin_filter #(
    parameter [`RCT_FILT_W-1:0] FILT_CYC = `RCT_FILT_CYC
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       pin_n_i,
    output reg        pin_sync_o,
    output reg        pin_low_o
);
    reg                   sync1;
    reg [`RCT_FILT_W-1:0] low_cnt;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1      <= 1'b1;
            pin_sync_o <= 1'b1;
            low_cnt    <= {`RCT_FILT_W{1'b0}};
            pin_low_o  <= 1'b0;
        end else begin
            sync1      <= pin_n_i;
            pin_sync_o <= sync1;
            if (pin_sync_o) begin
                low_cnt   <= {`RCT_FILT_W{1'b0}};
                pin_low_o <= 1'b0;
            end else if (low_cnt >= FILT_CYC - 1'b1) begin
                pin_low_o <= 1'b1;
            end else begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end
endmodule // rct_pin_filter

// ### rtl/rct_por_pulse.v
/*
 Power-on pulse generator: stretches a supply-good rise into a fixed pulse.
 Assumes the supply detector level is synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "rct_defs.vh"
module rct_por_pulse (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       supply_ok_i,
    output wire       por_o,
    output wire       por_start_o
);
    reg       ok_q;
    reg [2:0] cnt;

    assign por_start_o = supply_ok_i & ~ok_q;
    assign por_o       = (cnt != 3'h0) | por_start_o | ~supply_ok_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ok_q <= 1'b1; // Idle level of a good supply, no false pulse
            cnt  <= 3'h0;
        end else begin
            ok_q <= supply_ok_i;
            if (por_start_o)
                cnt <= `RCT_PULSE_CYC;
            else if (cnt != 3'h0)
                cnt <= cnt - 3'h1;
        end
    end
endmodule // rct_por_pulse

// ### rtl/rct_reset_cause.v
/*
 Reset cause tracking top: combines reset sources, keeps sticky cause flags,
 filters the external reset pin and offers a Wishbone classic slave.
 Assumes all inputs synchronous to clk_i; rst_i models the cold supply reset.
*/
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "rct_defs.vh"
// Notes on behaviour
// - Power-on, pin run, pin low-power, watchdog, brown-out, instruction, stack causes differ.
// - Lowest five cause register bits are event flags.
// - Flags are cleared by their event or by a software write of zero; software sets them to re-arm.
// - All flags read together reveal the latest reset type.
// - Cause register also holds priority enable and soft brown-out enable.
// - Low external reset pin holds the device in reset.
// - Short low pulses on the reset pin are ignored.
// - Weak pull-up is on while the pin serves as reset.
// - The pin is never driven by internal resets.
// - With reset function off the pin is a plain digital input.
// - A supply rise above threshold makes a power-on pulse.
// - Power-on flag goes to zero on power-on, kept on other resets.
// - Only software or rst_i returns the power-on flag to one.
// - Pin reset function is active when its enable bit is one.
module rct_reset_cause #(
    parameter [`RCT_FILT_W-1:0] FILT_CYC = `RCT_FILT_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        supply_ok_i,
    input  wire        brownout_reset_i,
    input  wire        watchdog_reset_i,
    input  wire        reset_instr_i,
    input  wire        stack_full_i,
    input  wire        stack_underflow_i,
    input  wire        power_managed_i,
    input  wire        ext_reset_pin_n_i,
    input  wire        ext_reset_pin_enable_i,
    output wire        ext_reset_pin_n_o,
    output wire        ext_reset_pin_n_oe_o,
    output wire        ext_reset_pin_pullup_o,
    output reg         pin_digital_o,
    output wire        sys_reset_o,
    output wire        priority_levels_enable_o,
    output wire        soft_brownout_enable_o,
    output wire        irq_o,
    input  wire [3:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);
    wire                 pin_sync;
    wire                 pin_low;
    wire                 por_active;
    wire                 por_start;
    wire                 pin_reset;
    wire                 any_reset;
    wire [`RCT_EV_W-1:0] ev_level;
    wire                 wr;
    wire                 wr_lane0;

    reg  [7:0]           reset_cause_control_reg;
    reg  [1:0]           stack_flags;
    reg  [`RCT_EV_W-1:0] ev_q;
    reg  [`RCT_EV_W-1:0] irq_stat;
    reg  [`RCT_EV_W-1:0] irq_mask;
    reg  [7:0]           next_cause;
    reg  [1:0]           next_stack;
    reg  [`RCT_EV_W-1:0] next_stat;

    rct_pin_filter #(
        .FILT_CYC   (FILT_CYC)
    ) u_filter (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_n_i    (ext_reset_pin_n_i),
        .pin_sync_o (pin_sync),
        .pin_low_o  (pin_low)
    );

    rct_por_pulse u_por (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .supply_ok_i (supply_ok_i),
        .por_o       (por_active),
        .por_start_o (por_start)
    );

    // Pin as reset or input
    assign pin_reset              = ext_reset_pin_enable_i & pin_low;
    assign ext_reset_pin_pullup_o = ext_reset_pin_enable_i;
    assign ext_reset_pin_n_o      = 1'b1;
    assign ext_reset_pin_n_oe_o   = 1'b0;

    always @(posedge clk_i) begin
        if (rst_i)
            pin_digital_o <= 1'b1;
        else if (!ext_reset_pin_enable_i)
            pin_digital_o <= pin_sync;
        else
            pin_digital_o <= 1'b1;
    end

    // Combined reset
    assign any_reset = por_active | brownout_reset_i | pin_reset | watchdog_reset_i
                     | reset_instr_i | stack_full_i | stack_underflow_i;
    assign sys_reset_o = rst_i | any_reset;

    // Source levels for edge detection
    assign ev_level[`RCT_EV_POR]     = por_start;
    assign ev_level[`RCT_EV_BOR]     = brownout_reset_i;
    assign ev_level[`RCT_EV_PIN_RUN] = pin_reset & ~power_managed_i;
    assign ev_level[`RCT_EV_PIN_PM]  = pin_reset & power_managed_i;
    assign ev_level[`RCT_EV_WDT]     = watchdog_reset_i;
    assign ev_level[`RCT_EV_RI]      = reset_instr_i;
    assign ev_level[`RCT_EV_STKFUL]  = stack_full_i;
    assign ev_level[`RCT_EV_STKUNF]  = stack_underflow_i;

    wire [`RCT_EV_W-1:0] ev_rise = ev_level & ~ev_q;

    assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign wr_lane0 = wr & wb_sel_i[0];

    // Cause flags: software write first, events then override
    always @* begin
        next_cause = reset_cause_control_reg;
        next_stack = stack_flags;
        if (wr_lane0 && wb_adr_i == `RCT_ADDR_CAUSE) begin
            next_cause = {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
        end
        if (wr_lane0 && wb_adr_i == `RCT_ADDR_PIN) begin
            next_stack = next_stack & ~wb_dat_i[1:0];
        end
        if (ev_rise[`RCT_EV_POR]) begin
            next_cause[`RCT_BIT_POR]  = 1'b0;
            next_cause[`RCT_BIT_BOR]  = 1'b0;
            next_cause[`RCT_BIT_RI]   = 1'b1;
            next_cause[`RCT_BIT_TO]   = 1'b1;
            next_cause[`RCT_BIT_PD]   = 1'b1;
            next_stack                = 2'h0;
        end
        if (ev_rise[`RCT_EV_BOR])
            next_cause[`RCT_BIT_BOR] = 1'b0;
        if (ev_rise[`RCT_EV_WDT]) begin
            next_cause[`RCT_BIT_TO] = 1'b0;
            next_cause[`RCT_BIT_PD] = ~power_managed_i;
        end
        if (ev_rise[`RCT_EV_PIN_PM])
            next_cause[`RCT_BIT_PD] = 1'b0;
        if (ev_rise[`RCT_EV_RI])
            next_cause[`RCT_BIT_RI] = 1'b0;
        if (ev_rise[`RCT_EV_STKFUL])
            next_stack[0] = 1'b1;
        if (ev_rise[`RCT_EV_STKUNF])
            next_stack[1] = 1'b1;
    end

    // Interrupt status: set wins over write-one-to-clear
    always @* begin
        next_stat = irq_stat;
        if (wr_lane0 && wb_adr_i == `RCT_ADDR_IRQ_STAT)
            next_stat = next_stat & ~wb_dat_i[`RCT_EV_W-1:0];
        next_stat = next_stat | ev_rise;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            reset_cause_control_reg <= `RCT_CAUSE_RESET;
            stack_flags             <= `RCT_STKFLAG_RESET;
            ev_q                    <= {`RCT_EV_W{1'b0}};
            irq_stat                <= {`RCT_EV_W{1'b0}};
            irq_mask                <= `RCT_MASK_RESET;
        end else begin
            reset_cause_control_reg <= next_cause;
            stack_flags             <= next_stack;
            ev_q                    <= ev_level;
            irq_stat                <= next_stat;
            if (wr_lane0 && wb_adr_i == `RCT_ADDR_IRQ_MASK)
                irq_mask <= wb_dat_i[`RCT_EV_W-1:0];
        end
    end

    assign priority_levels_enable_o = reset_cause_control_reg[`RCT_BIT_PRIORITY_LEVELS_ENABLE];
    assign soft_brownout_enable_o   = reset_cause_control_reg[`RCT_BIT_SOFT_BROWNOUT_ENABLE];
    assign irq_o                    = |(irq_stat & irq_mask);

    // Wishbone slave, one wait-free cycle answer
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                `RCT_ADDR_CAUSE:    wb_dat_o <= {24'h000000, reset_cause_control_reg};
                `RCT_ADDR_IRQ_STAT: wb_dat_o <= {24'h000000, irq_stat};
                `RCT_ADDR_IRQ_MASK: wb_dat_o <= {24'h000000, irq_mask};
                `RCT_ADDR_PIN:      wb_dat_o <= {28'h0000000, pin_sync, ext_reset_pin_enable_i, stack_flags};
                default:            wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // rct_reset_cause

// ### tb/rct_assertions.sv
/* Port checks on the reset cause block.
 Bound to rct_reset_cause; one clock, sync reset. */
`timescale 1ns/1ps
module rct_checker #(
    parameter int FILT_CYC = 20
) (
    input logic clk_i,
    input logic rst_i,
    input logic supply_ok_i,
    input logic brownout_reset_i,
    input logic watchdog_reset_i,
    input logic ext_reset_pin_n_i,
    input logic ext_reset_pin_enable_i,
    input logic ext_reset_pin_n_o,
    input logic ext_reset_pin_n_oe_o,
    input logic ext_reset_pin_pullup_o,
    input logic pin_digital_o,
    input logic sys_reset_o,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] low_run;
    always @(posedge clk_i) begin
        if (rst_i || !ext_reset_pin_enable_i || ext_reset_pin_n_i)
            low_run <= 8'h00;
        else if (low_run != 8'hff)
            low_run <= low_run + 8'h01;
    end
    chk_pin_undriven: assert property (!ext_reset_pin_n_oe_o && ext_reset_pin_n_o)
        else $error("reset pin driven");
    chk_pullup_cfg: assert property (ext_reset_pin_pullup_o == ext_reset_pin_enable_i)
        else $error("pull-up wrong");
    chk_wdt_merge: assert property (watchdog_reset_i |-> sys_reset_o)
        else $error("watchdog not merged");
    chk_bor_merge: assert property (brownout_reset_i |-> sys_reset_o)
        else $error("brown-out not merged");
    chk_por_pulse: assert property ($rose(supply_ok_i) |-> sys_reset_o [*5])
        else $error("power-on pulse short");
    chk_pin_hold: assert property (ext_reset_pin_enable_i && !ext_reset_pin_n_i && low_run >= FILT_CYC + 2
        |-> sys_reset_o) else $error("held pin gives no reset");
    chk_pin_digital: assert property ((!ext_reset_pin_enable_i && $stable(ext_reset_pin_n_i)) [*4]
        |-> pin_digital_o == ext_reset_pin_n_i) else $error("digital input wrong");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    cov_por: cover property ($rose(supply_ok_i));
    cov_pin: cover property ((ext_reset_pin_enable_i && !ext_reset_pin_n_i) [*8]);
    cov_write: cover property (wb_ack_o && wb_we_i);
endmodule // rct_checker
bind rct_reset_cause rct_checker #(.FILT_CYC(FILT_CYC)) chk (.*);

// ### tb/rct_pin_drv.sv
/* Board driver of the reset pin.
 Pulls low for n cycles, else pull-up level. */
`timescale 1ns/1ps
module rct_pin_drv (
    input  logic clk_i,
    output logic pin_n_o
);
    initial pin_n_o = 1'b1;
    task press(input int n);
        @(posedge clk_i) pin_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        pin_n_o <= 1'b1;
    endtask
endmodule // rct_pin_drv

// ### tb/tb_reset_cause_tracking.sv
/* Self-checking bench of the reset cause block.
 Drives Wishbone, sources and the pin driver. */
`timescale 1ns/1ps
module tb_reset_cause_tracking;
    logic clk_i = 0, rst_i = 1, supply_ok_i = 1, pm = 0, en = 1;
    logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [4:0] src = 0;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 0;
    logic [7:0] q, cz = 8'h1f, st = 0;
    wire pin, pw, po, oe, pu, pd, sr, ple, sbe, irq, ack;
    wire [31:0] dat;
    int errors = 0, checks_done = 0, nres = 0, n0 = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (sr) nres <= nres + 1;
    assign pw = oe ? po : pin;
    rct_pin_drv drv (.clk_i(clk_i), .pin_n_o(pin));
    rct_reset_cause #(.FILT_CYC(8'd4)) uut (.clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i),
        .brownout_reset_i(src[0]), .watchdog_reset_i(src[1]), .reset_instr_i(src[2]),
        .stack_full_i(src[3]), .stack_underflow_i(src[4]), .power_managed_i(pm),
        .ext_reset_pin_n_i(pw), .ext_reset_pin_enable_i(en), .ext_reset_pin_n_o(po),
        .ext_reset_pin_n_oe_o(oe), .ext_reset_pin_pullup_o(pu), .pin_digital_o(pd), .sys_reset_o(sr),
        .priority_levels_enable_o(ple), .soft_brownout_enable_o(sbe), .irq_o(irq), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(dat), .wb_ack_o(ack));
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task lvl(input got, input exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask
    task bus(input [3:0] a, input [7:0] d, input w);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_adr_i <= a; wb_we_i <= w; wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat[7:0];
        wb_cyc_i <= 0; wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task rd(input [3:0] a, input [7:0] e);
        bus(a, 8'h0, 1'b0);
        chk(q, e);
    endtask
    task fire(input [4:0] s);
        n0 = nres; src <= s;
        repeat (2) @(posedge clk_i);
        src <= 0;
        @(posedge clk_i);
    endtask
    initial begin #100000; errors++; end_of_test; end
    initial begin
        void'($urandom(32'h6563173b));
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rd(4'h0, 8'h1f);
        rd(4'h8, 8'h00);
        rd(4'h2, 8'h00);
        $display("test reset values done");
        n0 = nres; supply_ok_i <= 0;
        repeat (3) @(posedge clk_i);
        supply_ok_i <= 1;
        repeat (8) @(posedge clk_i);
        lvl(nres != n0, 1);
        cz = 8'h1c; st = 8'h01;
        rd(4'h0, cz);
        for (int i = 0; i < 5; i++) begin
            pm <= 1'($urandom);
            fire(5'h1 << i);
            case (i)
                0: begin cz[0] = 0; st[1] = 1; end
                1: begin cz[3] = 0; cz[2] = !pm; st[4] = 1; end
                2: begin cz[4] = 0; st[5] = 1; end
                default: st[i + 3] = 1;
            endcase
            lvl(nres != n0, 1);
            rd(4'h0, cz);
            rd(4'h4, st);
        end
        rd(4'hc, 8'h0f);
        bus(4'hc, 8'h01, 1);
        rd(4'hc, 8'h0e);
        $display("test sources done");
        bus(4'h0, 8'hdf, 1); cz = 8'hdf;
        rd(4'h0, cz);
        lvl(ple, 1);
        lvl(sbe, 1);
        lvl(irq, 0);
        bus(4'h8, 8'h10, 1);
        lvl(irq, 1);
        bus(4'h4, 8'h10, 1); st[4] = 0;
        lvl(irq, 0);
        rd(4'h4, st);
        wb_sel_i <= 4'h0;
        bus(4'h8, 8'hff, 1);
        wb_sel_i <= 4'h1;
        rd(4'h8, 8'h10);
        lvl(irq, 0);
        $display("test interrupt done");
        pm <= 0; n0 = nres;
        drv.press(2);
        repeat (6) @(posedge clk_i);
        lvl(nres != n0, 0);
        drv.press(10);
        lvl(nres != n0, 1);
        st[2] = 1;
        rd(4'h4, st);
        pm <= 1;
        drv.press(10);
        cz[2] = 0; st[3] = 1;
        rd(4'h0, cz);
        rd(4'h4, st);
        repeat (4) @(posedge clk_i);
        n0 = nres; en <= 0; pm <= 0;
        fork drv.press(20); join_none
        repeat (10) @(posedge clk_i);
        lvl(pd, 0);
        lvl(pu, 0);
        repeat (16) @(posedge clk_i);
        lvl(nres != n0, 0);
        lvl(pd, 1);
        $display("test pin done");
        end_of_test;
    end
endmodule // tb_reset_cause_tracking
